// ==== inc/serial_port_defs.svh ====
// Register offsets, field positions, codes and reset values of the serial channel
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

`define OFS_MODE        5'h00
`define OFS_CTRL0       5'h04
`define OFS_CTRL1       5'h08
`define OFS_BRG         5'h0C
`define OFS_TXBUF       5'h10
`define OFS_RXBUF       5'h14

`define MODE_PORT       3'h0
`define MODE_SYNC       3'h1
`define MODE_ASYNC7     3'h4
`define MODE_ASYNC8     3'h5
`define MODE_ASYNC9     3'h6

`define M_EXT_CLK       3
`define M_TWO_STOP      4
`define M_EVEN_PAR      5
`define M_PAR_EN        6
`define M_SLEEP         7

`define C0_CS_LO        0
`define C0_CS_HI        1
`define C0_RTS_SEL      2
`define C0_TX_IDLE      3
`define C0_PIN_PORT     4
`define C0_OPEN_DRAIN   5
`define C0_CLK_POL      6
`define C0_MSB_FIRST    7

`define C1_TX_ON        0
`define C1_RX_ON        2

`define SUB_LAST        4'hF
`define SUB_MID         4'h7

`define RST_MODE        8'h00
`define RST_CTRL0       8'h00
`define RST_BRG         8'h00

`endif

// ==== inc/serial_port_pkg.sv ====
// Types of the serial channel: state machine codes and the module state
package serial_port_pkg;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100
    } tx_state_e;

    typedef enum logic [0:0] {
        RX_IDLE = 1'b0,
        RX_BUSY = 1'b1
    } rx_state_e;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  ctrl0;
        logic [7:0]  brg;
        logic        tx_on;
        logic        rx_on;
        logic        tx_vac;
        logic        rx_full;
        logic        ovr;
        logic        fe;
        logic        pe;
        logic        sum;
        logic        tx_idle;
        logic        tend_prev;
        logic [5:0]  pre_cnt;
        logic [7:0]  brg_cnt;
        logic [3:0]  tx_sub;
        tx_state_e   txst;
        logic [3:0]  txcnt;
        logic [8:0]  txbuf;
        logic [8:0]  txsh;
        logic        tx_line;
        rx_state_e   rxst;
        logic [3:0]  rx_sub;
        logic [3:0]  rxcnt;
        logic [8:0]  rxsh;
        logic [8:0]  rxbuf;
        logic        rx_fe;
        logic        rx_pe;
        logic        ext_prev;
        logic        sclk_prev;
        logic        rxd_prev;
        logic        wreq;
        logic [8:0]  rdata;
        logic        txd;
        logic        txd_oe;
        logic        rts_n;
        logic        rts_oe;
        logic        tx_irq;
        logic        rx_irq;
    } state_s;

endpackage

// ==== src/serial_port.sv ====
// Serial channel: synchronous receive, asynchronous transmit and receive, Avalon-MM registers
// Notes on behaviour
// - Synchronous receive starts once rx_on set and the transmit buffer is loaded
// - Synchronous RTS follows rx_on, tx_buf_vacant, restart
// - Shift one bit per selected clock edge
// - Eight bits received: buffer, set rx_buf_full
// - rx_buf_full rising raises receive interrupt request
// - Overrun when buffer loaded while still full
// - Synchronous clears: read, rx_on off, port
// - Buffer read order follows msb_first_sel
// - Synchronous receive needs transmitter buffer loaded
// - Mode bits select 7, 8, 9 data
// - Clock source, divide n+1, then 16
// - Stop count, parity sense, parity enable
// - Handshake pin: CTS or RTS, or port
// - Transmit pin push-pull or open-drain
// - Start needs tx_on, loaded buffer, CTS low unless the pin is RTS or port
// - Buffer reload sets vacant, raises transmit request
// - Start condition checked only in done window
// - Idle flag set after window rises, cleared on start
// - Receive divider starts on start bit
// - Asynchronous RTS low when ready, high receiving
// - Framing, parity, overrun, summary flags and clears
// - Sleep drops words whose top bit is zero
`timescale 1ns/1ns
`include "serial_port_defs.svh"

module serial_port
    import serial_port_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        rxd_i,
    input  wire logic        sclk_i,
    input  wire logic        ext_clk_i,
    input  wire logic        cts_n_i,
    output logic             txd_o,
    output logic             txd_oe_o,
    output logic             rts_n_o,
    output logic             rts_oe_o,
    output logic             tx_irq_o,
    output logic             rx_irq_o
);

    state_s     s_q;
    state_s     s_d;

    logic       int_tick;
    logic       src_tick;
    logic       tick16;
    logic       bit_tick;
    logic [3:0] len;
    logic [8:0] dmask;
    logic [3:0] stops;
    logic [3:0] total;
    logic       par_en;
    logic       async_mode;
    logic       sync_mode;
    logic       port_mode;
    logic       start_ok;
    logic       tend;
    logic       tx_par;
    logic       sedge;
    logic       deliver;
    logic [8:0] dword;
    logic       d_fe;
    logic       fe_now;
    logic [8:0] rd_val;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.tx_irq = 1'b0;
        s_d.rx_irq = 1'b0;
        s_d.ext_prev = ext_clk_i;
        s_d.sclk_prev = sclk_i;
        s_d.rxd_prev = rxd_i;
        deliver = 1'b0;
        dword = 9'h000;
        d_fe = 1'b0;
        fe_now = 1'b0;

        // Format decode
        port_mode = (s_q.mode[2:0] == `MODE_PORT);
        sync_mode = (s_q.mode[2:0] == `MODE_SYNC);
        async_mode = (s_q.mode[2:0] == `MODE_ASYNC7) || (s_q.mode[2:0] == `MODE_ASYNC8)
                     || (s_q.mode[2:0] == `MODE_ASYNC9);
        unique case (s_q.mode[2:0])
            `MODE_ASYNC7: begin
                len = 4'd7;
                dmask = 9'h07F;
            end
            `MODE_ASYNC9: begin
                len = 4'd9;
                dmask = 9'h1FF;
            end
            default: begin
                len = 4'd8;
                dmask = 9'h0FF;
            end
        endcase
        stops = s_q.mode[`M_TWO_STOP] ? 4'd2 : 4'd1;
        par_en = s_q.mode[`M_PAR_EN];
        total = 4'd1 + len + {3'b000, par_en} + stops;

        // Bit clock: source select, divide by n+1, then by 16
        s_d.pre_cnt = s_q.pre_cnt + 6'h01;
        unique case ({s_q.ctrl0[`C0_CS_HI], s_q.ctrl0[`C0_CS_LO]})
            2'b00: int_tick = 1'b1;
            2'b01: int_tick = &s_q.pre_cnt[2:0];
            2'b10: int_tick = &s_q.pre_cnt[4:0];
            2'b11: int_tick = &s_q.pre_cnt;
        endcase
        src_tick = s_q.mode[`M_EXT_CLK] ? (ext_clk_i & ~s_q.ext_prev) : int_tick;
        tick16 = 1'b0;
        if (src_tick) begin
            if (s_q.brg_cnt == 8'h00) begin
                s_d.brg_cnt = s_q.brg;
                tick16 = 1'b1;
            end else begin
                s_d.brg_cnt = s_q.brg_cnt - 8'h01;
            end
        end
        if (tick16) begin
            s_d.tx_sub = s_q.tx_sub + 4'h1;
        end
        bit_tick = tick16 && (s_q.tx_sub == `SUB_LAST);

        // Read value
        unique case (avs_address_i)
            `OFS_MODE:  rd_val = {1'b0, s_q.mode};
            `OFS_CTRL0: rd_val = {1'b0, s_q.ctrl0[7:4], s_q.tx_idle, s_q.ctrl0[2:0]};
            `OFS_CTRL1: rd_val = {1'b0, s_q.sum, s_q.pe, s_q.fe, s_q.ovr, s_q.rx_full,
                                  s_q.rx_on, s_q.tx_vac, s_q.tx_on};
            `OFS_BRG:   rd_val = {1'b0, s_q.brg};
            `OFS_TXBUF: rd_val = s_q.txbuf;
            `OFS_RXBUF: rd_val = (sync_mode && s_q.ctrl0[`C0_MSB_FIRST])
                                 ? {1'b0, rev8(s_q.rxbuf[7:0])} : s_q.rxbuf;
            default:    rd_val = 9'h000;
        endcase

        // Bus slave: one wait cycle, effect on the cycle waitrequest is low
        if ((avs_read_i || avs_write_i) && s_q.wreq) begin
            s_d.wreq = 1'b0;
            s_d.rdata = rd_val;
        end else if ((avs_read_i || avs_write_i) && !s_q.wreq) begin
            s_d.wreq = 1'b1;
            if (avs_write_i && avs_byteenable_i[0]) begin
                unique case (avs_address_i)
                    `OFS_MODE:  s_d.mode = avs_writedata_i[7:0];
                    `OFS_CTRL0: s_d.ctrl0 = avs_writedata_i[7:0];
                    `OFS_CTRL1: begin
                        s_d.tx_on = avs_writedata_i[`C1_TX_ON];
                        s_d.rx_on = avs_writedata_i[`C1_RX_ON];
                    end
                    `OFS_BRG:   s_d.brg = avs_writedata_i[7:0];
                    `OFS_TXBUF: begin
                        s_d.txbuf = avs_writedata_i[8:0];
                        s_d.tx_vac = 1'b0;
                    end
                    default: ;
                endcase
            end
            if (avs_read_i && avs_address_i == `OFS_RXBUF) begin
                s_d.rx_full = 1'b0;
                if (!sync_mode) begin
                    s_d.fe = 1'b0;
                    s_d.pe = 1'b0;
                end
            end
        end
        if (!s_d.rx_on || port_mode) begin
            s_d.rx_full = 1'b0;
            s_d.ovr = 1'b0;
            s_d.fe = 1'b0;
            s_d.pe = 1'b0;
            s_d.sum = 1'b0;
        end

        // Asynchronous transmitter
        start_ok = s_q.tx_on && !s_q.tx_vac && async_mode
                   && (s_q.ctrl0[`C0_PIN_PORT] || s_q.ctrl0[`C0_RTS_SEL] || !cts_n_i);
        tend = (s_q.txst == TX_IDLE) || (s_q.txst == TX_STOP && s_q.txcnt == stops - 4'd1);
        tx_par = ^(s_q.txsh & dmask) ^ ~s_q.mode[`M_EVEN_PAR];
        s_d.tend_prev = tend;
        if (tend && !s_q.tend_prev) begin
            s_d.tx_idle = 1'b1;
        end
        if (!async_mode) begin
            s_d.txst = TX_IDLE;
            s_d.tx_line = 1'b1;
        end else if (bit_tick) begin
            unique case (s_q.txst)
                TX_START: begin
                    s_d.txst = TX_DATA;
                    s_d.txcnt = 4'd0;
                    s_d.tx_line = s_q.txsh[0];
                end
                TX_DATA: begin
                    if (s_q.txcnt == len - 4'd1) begin
                        s_d.txcnt = 4'd0;
                        s_d.txst = par_en ? TX_PAR : TX_STOP;
                        s_d.tx_line = par_en ? tx_par : 1'b1;
                    end else begin
                        s_d.txcnt = s_q.txcnt + 4'd1;
                        s_d.tx_line = s_q.txsh[s_q.txcnt + 4'd1];
                    end
                end
                TX_PAR: begin
                    s_d.txst = TX_STOP;
                    s_d.txcnt = 4'd0;
                    s_d.tx_line = 1'b1;
                end
                TX_STOP: begin
                    if (s_q.txcnt != stops - 4'd1) begin
                        s_d.txcnt = s_q.txcnt + 4'd1;
                    end else begin
                        s_d.txst = TX_IDLE;
                    end
                end
                TX_IDLE: ;
                default: s_d.txst = TX_IDLE;
            endcase
            // Start condition is only looked at inside the done window
            if (tend && start_ok) begin
                s_d.txsh = s_q.txbuf;
                s_d.tx_vac = 1'b1;
                s_d.tx_irq = 1'b1;
                s_d.txst = TX_START;
                s_d.tx_line = 1'b0;
                s_d.tx_idle = 1'b0;
            end
        end

        // Asynchronous receiver
        if (async_mode) begin
            if (!s_q.rx_on) begin
                s_d.rxst = RX_IDLE;
            end else begin
                unique case (s_q.rxst)
                    RX_IDLE: begin
                        if (s_q.rxd_prev && !rxd_i) begin
                            s_d.rxst = RX_BUSY;
                            s_d.rx_sub = 4'h0;
                            s_d.rxcnt = 4'd0;
                            s_d.rx_fe = 1'b0;
                            s_d.rx_pe = 1'b0;
                        end
                    end
                    RX_BUSY: begin
                        if (tick16) begin
                            s_d.rx_sub = s_q.rx_sub + 4'h1;
                            if (s_q.rx_sub == `SUB_MID) begin
                                s_d.rxcnt = s_q.rxcnt + 4'd1;
                                fe_now = s_q.rx_fe;
                                if (s_q.rxcnt == 4'd0) begin
                                    if (rxd_i) begin
                                        s_d.rxst = RX_IDLE;
                                    end
                                end else if (s_q.rxcnt <= len) begin
                                    s_d.rxsh[s_q.rxcnt - 4'd1] = rxd_i;
                                end else if (par_en && s_q.rxcnt == len + 4'd1) begin
                                    s_d.rx_pe = ^(s_q.rxsh & dmask) ^ rxd_i
                                                ^ ~s_q.mode[`M_EVEN_PAR];
                                end else begin
                                    fe_now = s_q.rx_fe | ~rxd_i;
                                    s_d.rx_fe = fe_now;
                                end
                                if (s_q.rxcnt == total - 4'd1) begin
                                    s_d.rxst = RX_IDLE;
                                    if (!s_q.mode[`M_SLEEP] || s_q.rxsh[len - 4'd1]) begin
                                        deliver = 1'b1;
                                        dword = s_q.rxsh & dmask;
                                        d_fe = fe_now;
                                    end
                                end
                            end
                        end
                    end
                endcase
            end
        end else begin
            s_d.rxst = RX_IDLE;
        end

        // Synchronous receiver
        sedge = s_q.ctrl0[`C0_CLK_POL] ? (s_q.sclk_prev & ~sclk_i)
                                        : (~s_q.sclk_prev & sclk_i);
        if (!sync_mode || !s_q.rx_on) begin
            // An idle async receiver leaves no stale count for sync mode
            if (!async_mode || s_q.rxst == RX_IDLE) begin
                s_d.rxcnt = 4'd0;
            end
        end else if (sedge && (s_q.rxcnt != 4'd0 || !s_q.tx_vac)) begin
            s_d.rxsh = {1'b0, rxd_i, s_q.rxsh[7:1]};
            if (s_q.rxcnt == 4'd7) begin
                s_d.rxcnt = 4'd0;
                s_d.tx_vac = 1'b1;
                deliver = 1'b1;
                dword = {1'b0, rxd_i, s_q.rxsh[7:1]};
            end else begin
                s_d.rxcnt = s_q.rxcnt + 4'd1;
            end
        end

        // Buffer transfer: hardware set wins over any clear this cycle
        if (deliver) begin
            s_d.rxbuf = dword;
            if (s_q.rx_full && s_d.rx_full) begin
                s_d.ovr = 1'b1;
            end
            if (!s_d.rx_full) begin
                s_d.rx_irq = 1'b1;
            end
            s_d.rx_full = 1'b1;
            s_d.fe = s_d.fe | d_fe;
            s_d.pe = s_d.pe | s_d.rx_pe;
            s_d.sum = s_d.sum | s_d.ovr | s_d.fe | s_d.pe;
        end

        // Pin drivers
        if (sync_mode) begin
            s_d.rts_n = !(s_d.rx_on && !s_d.tx_vac && s_d.rxcnt == 4'd0);
        end else begin
            s_d.rts_n = !(s_d.rx_on && s_d.rxst == RX_IDLE);
        end
        s_d.rts_oe = !s_d.ctrl0[`C0_PIN_PORT] && s_d.ctrl0[`C0_RTS_SEL]
                     && !port_mode;
        s_d.txd = s_d.ctrl0[`C0_OPEN_DRAIN] ? 1'b0 : s_d.tx_line;
        s_d.txd_oe = s_d.ctrl0[`C0_OPEN_DRAIN] ? !s_d.tx_line : 1'b1;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.mode <= `RST_MODE;
            s_q.ctrl0 <= `RST_CTRL0;
            s_q.brg <= `RST_BRG;
            s_q.tx_vac <= 1'b1;
            s_q.tx_idle <= 1'b1;
            s_q.tend_prev <= 1'b1;
            s_q.txst <= TX_IDLE;
            s_q.rxst <= RX_IDLE;
            s_q.tx_line <= 1'b1;
            s_q.ext_prev <= 1'b0;
            s_q.sclk_prev <= 1'b0;
            s_q.rxd_prev <= 1'b1;
            s_q.wreq <= 1'b1;
            s_q.txd <= 1'b1;
            s_q.txd_oe <= 1'b1;
            s_q.rts_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_o = {23'h000000, s_q.rdata};
    assign avs_waitrequest_o = s_q.wreq;
    assign txd_o = s_q.txd;
    assign txd_oe_o = s_q.txd_oe;
    assign rts_n_o = s_q.rts_n;
    assign rts_oe_o = s_q.rts_oe;
    assign tx_irq_o = s_q.tx_irq;
    assign rx_irq_o = s_q.rx_irq;

endmodule

// ==== dv/serial_port_checker.sv ====
// Port-level assertions for the serial channel
`timescale 1ns/1ns
module serial_port_checker (
    input wire logic        clock_i,
    input wire logic        srst_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        txd_o,
    input wire logic        txd_oe_o,
    input wire logic        rts_oe_o,
    input wire logic        tx_irq_o,
    input wire logic        rx_irq_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    logic       line;
    logic [7:0] gap_q;
    logic [7:0] gap_d;
    // Released open-drain line floats high
    assign line = txd_oe_o ? txd_o : 1'b1;
    always_comb begin
        gap_d = (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
        if (tx_irq_o) begin
            gap_d = 8'h00;
        end
    end
    always_ff @(posedge clock_i) begin
        gap_q <= srst_i ? 8'hFF : gap_d;
    end
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    sequence s_start_bit;
        (!line) [*8];
    endsequence
    property p_bus_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_answer;
    endproperty
    property p_read_width;
        avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:9] == 23'h0;
    endproperty
    property p_tx_pulse;
        tx_irq_o |=> !tx_irq_o;
    endproperty
    property p_tx_start;
        tx_irq_o |=> s_start_bit;
    endproperty
    property p_bit_hold;
        $changed(line) |=> $stable(line) [*7];
    endproperty
    property p_open_drain;
        !txd_oe_o |-> !txd_o;
    endproperty
    property p_rx_pulse;
        rx_irq_o |=> !rx_irq_o;
    endproperty
    property p_frame_gap;
        tx_irq_o |-> gap_q >= 8'h8F;
    endproperty
    property p_pin_cfg;
        $changed(rts_oe_o) |-> $past(avs_write_i) || $past(avs_write_i, 2) || $past(avs_write_i, 3);
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
    a_read_width: assert property (p_read_width) else $error("read high bits set");
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx request too long");
    a_tx_start: assert property (p_tx_start) else $error("start bit missing");
    a_bit_hold: assert property (p_bit_hold) else $error("bit too short");
    a_open_drain: assert property (p_open_drain) else $error("drain drives high");
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx request too long");
    a_frame_gap: assert property (p_frame_gap) else $error("frame cut short");
    a_pin_cfg: assert property (p_pin_cfg) else $error("pin mode moved alone");
endmodule

bind serial_port serial_port_checker chk (
    .clock_i(clock_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
    .rts_oe_o(rts_oe_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o)
);

// ==== dv/serial_peer.sv ====
// Far-end serial device: sends async and sync words, decodes sent frames
`timescale 1ns/1ns
module serial_peer (
    input  wire logic       clock_i,
    input  wire logic       txd_i,
    input  wire logic       txd_oe_i,
    output logic            rxd_o,
    output logic            sclk_o,
    output logic            got_o,
    output logic [7:0]      byte_o
);
    logic       line;
    logic [7:0] rx_d;
    initial rxd_o = 1'b1;
    initial sclk_o = 1'b1;
    initial got_o = 1'b0;
    initial byte_o = 8'h00;
    assign line = txd_oe_i ? txd_i : 1'b1; // Pull-up on the released line
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic send_async(input logic [7:0] d, input logic stop);
        rxd_o <= 1'b0;
        wait_n(16);
        for (int i = 0; i < 8; i++) begin
            rxd_o <= d[i];
            wait_n(16);
        end
        rxd_o <= stop;
        wait_n(16);
        rxd_o <= 1'b1;
    endtask
    task automatic send_sync(input logic [7:0] d, input logic pol);
        for (int i = 0; i < 8; i++) begin
            rxd_o <= d[i];
            sclk_o <= pol;
            wait_n(8);
            sclk_o <= ~pol;
            wait_n(8);
        end
        rxd_o <= ~d[7];
    endtask
    task automatic set_idle(input logic pol);
        sclk_o <= ~pol;
    endtask
    // Decode LSB-first frames at mid-bit; high again at mid-start is a pin-mode glitch
    always begin
        @(negedge line);
        wait_n(8);
        if (line === 1'b0) begin
            for (int j = 0; j < 8; j++) begin
                wait_n(16);
                rx_d[j] = line;
            end
            got_o <= 1'b1;
            byte_o <= rx_d;
            wait_n(1);
            got_o <= 1'b0;
            wait_n(16);
        end
    end
endmodule

// ==== dv/serial_port_test.sv ====
// Self-checking bench for the serial channel
`timescale 1ns/1ns
`include "serial_port_defs.svh"
module serial_port_test;
    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic        cts_n = 1'b0;
    logic [31:0] rdata;
    logic        wreq, txd, txd_oe, rts_n, rts_oe, tx_irq, rx_irq, rxd, sclk, got;
    logic [7:0]  gbyte, b;
    logic [31:0] exp_q[$];
    logic [31:0] tx_q[$];
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #4 clock_i = ~clock_i;
    serial_port DUT (.clock_i(clock_i), .srst_i(srst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .rxd_i(rxd), .sclk_i(sclk),
        .ext_clk_i(1'b0), .cts_n_i(cts_n), .txd_o(txd), .txd_oe_o(txd_oe), .rts_n_o(rts_n),
        .rts_oe_o(rts_oe), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
    serial_peer peer (.clock_i(clock_i), .txd_i(txd), .txd_oe_i(txd_oe), .rxd_o(rxd),
        .sclk_o(sclk), .got_o(got), .byte_o(gbyte));
    task automatic compare_data(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic compare_pin(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= d;
        do @(posedge clock_i); while (wreq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic check_rts(input logic e);
        @(negedge clock_i);
        compare_pin(rts_n, e);
        @(posedge clock_i);
    endtask
    task automatic print_verdict();
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (rd === 1'b1 && wreq === 1'b0)
            compare_data(rdata, exp_q.size() ? exp_q.pop_front() : 32'hDEAD);
        if (got === 1'b1)
            compare_data({24'h0, gbyte}, tx_q.size() ? tx_q.pop_front() : 32'hDEAD);
        if (cycles == 9000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h330B));
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        rd_chk(`OFS_MODE, 32'h00);
        rd_chk(`OFS_CTRL0, 32'h08);
        rd_chk(`OFS_CTRL1, 32'h02);
        rd_chk(5'h1C, 32'h00);
        be <= 4'hE;
        bus(`OFS_BRG, 1'b1, 32'h55);
        be <= 4'hF;
        rd_chk(`OFS_BRG, 32'h00);
        bus(`OFS_MODE, 1'b1, 32'h05);
        bus(`OFS_CTRL0, 1'b1, 32'h20); // Open drain, bits 6 and 7 zero
        bus(`OFS_CTRL1, 1'b1, 32'h01);
        cts_n <= 1'b1;
        b = 8'($urandom);
        tx_q.push_back({24'h0, b});
        bus(`OFS_TXBUF, 1'b1, {24'h0, b});
        repeat (64) @(posedge clock_i);
        rd_chk(`OFS_CTRL1, 32'h01);
        cts_n <= 1'b0;
        do @(negedge clock_i); while (tx_irq !== 1'b1);
        b = 8'($urandom);
        tx_q.push_back({24'h0, b});
        bus(`OFS_TXBUF, 1'b1, {24'h0, b});
        while (tx_q.size() != 0) @(posedge clock_i);
        repeat (40) @(posedge clock_i);
        rd_chk(`OFS_CTRL0, 32'h28);
        bus(`OFS_CTRL0, 1'b1, 32'h04);
        bus(`OFS_CTRL1, 1'b1, 32'h05);
        check_rts(1'b0);
        compare_pin(rts_oe, 1'b1);
        b = 8'($urandom);
        fork
            peer.send_async(b, 1'b1);
            begin
                repeat (40) @(posedge clock_i);
                check_rts(1'b1);
            end
        join
        rd_chk(`OFS_CTRL1, 32'h0F);
        b = 8'($urandom);
        peer.send_async(b, 1'b1);
        rd_chk(`OFS_CTRL1, 32'h9F);
        rd_chk(`OFS_RXBUF, {24'h0, b});
        rd_chk(`OFS_CTRL1, 32'h97);
        peer.send_async(8'($urandom), 1'b0);
        rd_chk(`OFS_CTRL1, 32'hBF);
        bus(`OFS_CTRL1, 1'b1, 32'h01);
        rd_chk(`OFS_CTRL1, 32'h03);
        bus(`OFS_CTRL1, 1'b1, 32'h05);
        bus(`OFS_MODE, 1'b1, 32'h85);
        b = 8'($urandom);
        peer.send_async(b & 8'h7F, 1'b1);
        rd_chk(`OFS_CTRL1, 32'h07);
        peer.send_async(b | 8'h80, 1'b1);
        rd_chk(`OFS_RXBUF, {24'h0, b | 8'h80});
        bus(`OFS_MODE, 1'b1, 32'h01);
        bus(`OFS_CTRL0, 1'b1, 32'h84);
        bus(`OFS_CTRL1, 1'b1, 32'h04);
        check_rts(1'b1);
        bus(`OFS_TXBUF, 1'b1, 32'h00);
        check_rts(1'b0);
        b = 8'($urandom);
        peer.send_sync(b, 1'b0);
        b = {<<{b}};
        rd_chk(`OFS_RXBUF, {24'h0, b});
        rd_chk(`OFS_CTRL1, 32'h06);
        bus(`OFS_CTRL0, 1'b1, 32'h40);
        peer.set_idle(1'b1);
        bus(`OFS_TXBUF, 1'b1, 32'h00);
        b = 8'($urandom);
        peer.send_sync(b, 1'b1);
        bus(`OFS_MODE, 1'b1, 32'h00);
        rd_chk(`OFS_CTRL1, 32'h06);
        rd_chk(`OFS_RXBUF, {24'h0, b});
        print_verdict();
    end
endmodule
